// ### inc/hsl_pkg.sv
package hsl_pkg;

   localparam int HSL_NPORT = 7;
   localparam int HSL_ADDR_W = 4;
   localparam int HSL_DATA_W = 32;

   localparam logic [HSL_ADDR_W-1:0] HSL_ADDR_CTRL = 4'h0;
   localparam logic [HSL_ADDR_W-1:0] HSL_ADDR_STATUS = 4'h4;

   localparam int HSL_CTRL_EXT_CFG = 0;
   localparam int HSL_CTRL_EXT_LED = 1;
   localparam logic HSL_CTRL_EXT_CFG_RST = 1'h0;
   localparam logic HSL_CTRL_EXT_LED_RST = 1'h0;

   localparam int HSL_ST_POL = 0;
   localparam int HSL_ST_PD_LO = 1;
   localparam int HSL_ST_PD_HI = 2;
   localparam int HSL_ST_NR_LO = 3;
   localparam int HSL_ST_NR_HI = 4;
   localparam int HSL_ST_INDICATOR_ENABLE_STRAP = 5;
   localparam int HSL_ST_MTT = 6;
   localparam int HSL_ST_GANG = 7;
   localparam int HSL_ST_VBUS = 8;
   localparam int HSL_ST_RUN = 9;

   localparam int HSL_P_GR_LOW_HI = 4;
   localparam int HSL_P_GR_LOW_LO = 3;
   localparam int HSL_P_NR_HI = 2;
   localparam int HSL_P_NR_LO = 1;
   localparam int HSL_P_AM_INDICATOR_ENABLE_STRAP = 4;
   localparam int HSL_P_AM_FIXED = 3;
   localparam int HSL_P_AM_MTT = 2;
   localparam int HSL_P_AM_GANG = 1;

   localparam logic [1:0] HSL_CODE_NONE = 2'h0;
   localparam logic [1:0] HSL_CODE_ONE = 2'h1;
   localparam logic [1:0] HSL_CODE_TWO = 2'h2;
   localparam logic [1:0] HSL_CODE_THREE = 2'h3;

   localparam logic [7:1] HSL_MASK_NONE = 7'h00;
   localparam logic [7:1] HSL_DIS_ONE = 7'h40;
   localparam logic [7:1] HSL_DIS_TWO = 7'h60;
   localparam logic [7:1] HSL_DIS_THREE = 7'h70;
   localparam logic [7:1] HSL_FIX_ONE = 7'h01;
   localparam logic [7:1] HSL_FIX_TWO = 7'h03;
   localparam logic [7:1] HSL_FIX_THREE = 7'h07;
   localparam logic [7:1] HSL_ALL_LOW = 7'h7F;

   typedef enum logic [1:0] {
      HSL_HOLD = 2'h1,
      HSL_RUN = 2'h2
   } hsl_state_t;

endpackage : hsl_pkg

// ### rtl/hsl_strap_led.sv
// Summary of operation
// RULE_01 - Connect pull-up follows detected upstream power.
// RULE_02 - One power enable output per port 1-7.
// RULE_03 - Power enable level follows polarity strap.
// RULE_04 - Green LEDs 7-5 always active low.
// RULE_05 - External config: green 4,3 active low.
// RULE_06 - Internal config: sample port-disable strap at release.
// RULE_07 - Disable code drops ports 7, 6, 5.
// RULE_08 - Disable bits set green 4,3 polarity.
// RULE_09 - Internal config: sample fixed-device strap at release.
// RULE_10 - Fixed code marks ports 1, 2, 3.
// RULE_11 - Fixed bits set green 2,1 polarity.
// RULE_12 - External config: green 2,1 active low.
// RULE_13 - Amber LEDs 7-5 always active low.
// RULE_14 - Polarity strap live in reset, latched after.
// RULE_15 - Amber 4 strap enables LED support.
// RULE_16 - Amber 2 strap selects multi translator.
// RULE_17 - Amber 1 strap selects ganged power.
// RULE_18 - Sampled straps held until next reset.
//
// Decided for this implementation: the address-and-strobe port and the address map.
module hsl_strap_led
   import hsl_pkg::*;
#(
   parameter int NPORT = HSL_NPORT,
   parameter int ADDR_W = HSL_ADDR_W,
   parameter int DATA_W = HSL_DATA_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic upstream_power_detect,
   output logic pullup_enable,
   input wire logic power_polarity_strap,
   input wire logic [NPORT:1] port_power_req,
   output logic [NPORT:1] port_power_enable_out,
   input wire logic [NPORT:1] green_req,
   input wire logic [NPORT:1] amber_req,
   input wire logic [NPORT:1] first_colour_led_in,
   output logic [NPORT:1] first_colour_led_out,
   output logic [NPORT:1] first_colour_led_oe_n,
   input wire logic [NPORT:1] second_colour_led_in,
   output logic [NPORT:1] second_colour_led_out,
   output logic [NPORT:1] second_colour_led_oe_n,
   output logic [NPORT:1] port_disabled,
   output logic [NPORT:1] port_fixed,
   output logic gang_mode,
   output logic multi_translator_en,
   output logic led_support
);

   // Pin synchronisers; the first stage feeds only the second.
   logic [NPORT:1] gr_meta;
   logic [NPORT:1] gr_sync;
   logic [NPORT:1] am_meta;
   logic [NPORT:1] am_sync;
   logic pol_meta;
   logic pol_sync;
   logic vbus_meta;
   logic vbus_sync;

   always_ff @(posedge clk) begin
      gr_meta <= first_colour_led_in;
      gr_sync <= gr_meta;
      am_meta <= second_colour_led_in;
      am_sync <= am_meta;
      pol_meta <= power_polarity_strap;
      pol_sync <= pol_meta;
      vbus_meta <= upstream_power_detect;
      vbus_sync <= vbus_meta;
   end

   // Strap capture happens once, in the first cycle after reset release.
   // The LED pins stay released through reset so the straps settle.
   hsl_state_t state;
   hsl_state_t next_state;
   logic pol;
   logic next_pol;
   logic [1:0] port_disable_strap;
   logic [1:0] next_port_disable_strap;
   logic [1:0] fixed_device_strap;
   logic [1:0] next_fixed_device_strap;
   logic indicator_enable_strap;
   logic next_indicator_enable_strap;
   logic multi_translator_strap;
   logic next_multi_translator_strap;
   logic gang_strap;
   logic next_gang_strap;

   always_comb begin
      next_state = state;
      next_pol = pol;
      next_port_disable_strap = port_disable_strap;
      next_fixed_device_strap = fixed_device_strap;
      next_indicator_enable_strap = indicator_enable_strap;
      next_multi_translator_strap = multi_translator_strap;
      next_gang_strap = gang_strap;
      unique case (state)
         HSL_HOLD: begin
            next_state = HSL_RUN;
            next_pol = pol_sync; // RULE_14
            next_port_disable_strap = {gr_sync[HSL_P_GR_LOW_HI],
                                       gr_sync[HSL_P_GR_LOW_LO]}; // RULE_06
            next_fixed_device_strap = {gr_sync[HSL_P_NR_HI], gr_sync[HSL_P_NR_LO]}; // RULE_09
            next_indicator_enable_strap = am_sync[HSL_P_AM_INDICATOR_ENABLE_STRAP]; // RULE_15
            next_multi_translator_strap = am_sync[HSL_P_AM_MTT]; // RULE_16
            next_gang_strap = am_sync[HSL_P_AM_GANG]; // RULE_17
         end
         HSL_RUN: begin
            next_state = HSL_RUN; // RULE_18
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= HSL_HOLD;
         pol <= 1'h0;
         port_disable_strap <= HSL_CODE_NONE;
         fixed_device_strap <= HSL_CODE_NONE;
         indicator_enable_strap <= 1'h0;
         multi_translator_strap <= 1'h0;
         gang_strap <= 1'h0;
      end else begin
         state <= next_state;
         pol <= next_pol;
         port_disable_strap <= next_port_disable_strap;
         fixed_device_strap <= next_fixed_device_strap;
         indicator_enable_strap <= next_indicator_enable_strap;
         multi_translator_strap <= next_multi_translator_strap;
         gang_strap <= next_gang_strap;
      end
   end

   // Control register: configuration source and externally set LED support.
   logic ext_cfg;
   logic next_ext_cfg;
   logic ext_led;
   logic next_ext_led;
   logic [DATA_W-1:0] next_reg_rdata;
   logic [DATA_W-1:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[HSL_ST_POL] = pol;
      status_word[HSL_ST_PD_LO] = port_disable_strap[0];
      status_word[HSL_ST_PD_HI] = port_disable_strap[1];
      status_word[HSL_ST_NR_LO] = fixed_device_strap[0];
      status_word[HSL_ST_NR_HI] = fixed_device_strap[1];
      status_word[HSL_ST_INDICATOR_ENABLE_STRAP] = indicator_enable_strap;
      status_word[HSL_ST_MTT] = multi_translator_strap;
      status_word[HSL_ST_GANG] = gang_strap;
      status_word[HSL_ST_VBUS] = vbus_sync;
      status_word[HSL_ST_RUN] = (state == HSL_RUN);
      next_ext_cfg = ext_cfg;
      next_ext_led = ext_led;
      if (reg_wr && reg_addr == HSL_ADDR_CTRL) begin
         next_ext_cfg = reg_wdata[HSL_CTRL_EXT_CFG];
         next_ext_led = reg_wdata[HSL_CTRL_EXT_LED];
      end
      next_reg_rdata = '0;
      if (reg_rd) begin
         if (reg_addr == HSL_ADDR_CTRL) begin
            next_reg_rdata[HSL_CTRL_EXT_CFG] = ext_cfg;
            next_reg_rdata[HSL_CTRL_EXT_LED] = ext_led;
         end else if (reg_addr == HSL_ADDR_STATUS) begin
            next_reg_rdata = status_word;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_cfg <= HSL_CTRL_EXT_CFG_RST;
         ext_led <= HSL_CTRL_EXT_LED_RST;
         reg_rdata <= '0;
      end else begin
         ext_cfg <= next_ext_cfg;
         ext_led <= next_ext_led;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Strap decode. In external configuration the LED pin straps no longer matter.
   logic [NPORT:1] dis_mask;
   logic [NPORT:1] fix_mask;
   logic [NPORT:1] gr_low;
   logic [NPORT:1] am_low;
   logic [NPORT:1] am_dark;
   logic support;

   always_comb begin
      unique case (port_disable_strap) // RULE_07
         HSL_CODE_NONE: dis_mask = HSL_MASK_NONE;
         HSL_CODE_ONE: dis_mask = HSL_DIS_ONE;
         HSL_CODE_TWO: dis_mask = HSL_DIS_TWO;
         HSL_CODE_THREE: dis_mask = HSL_DIS_THREE;
      endcase
      unique case (fixed_device_strap) // RULE_10
         HSL_CODE_NONE: fix_mask = HSL_MASK_NONE;
         HSL_CODE_ONE: fix_mask = HSL_FIX_ONE;
         HSL_CODE_TWO: fix_mask = HSL_FIX_TWO;
         HSL_CODE_THREE: fix_mask = HSL_FIX_THREE;
      endcase
      if (ext_cfg) begin
         dis_mask = HSL_MASK_NONE;
         fix_mask = HSL_MASK_NONE;
      end
      support = ext_cfg ? ext_led : indicator_enable_strap;
      gr_low = HSL_ALL_LOW; // RULE_04
      am_low = HSL_ALL_LOW; // RULE_13
      am_dark = HSL_MASK_NONE;
      if (ext_cfg) begin
         am_dark = support ? HSL_MASK_NONE : HSL_ALL_LOW; // RULE_05 RULE_12
      end else begin
         gr_low[HSL_P_GR_LOW_HI] = port_disable_strap[1]; // RULE_08
         gr_low[HSL_P_GR_LOW_LO] = port_disable_strap[0]; // RULE_08
         gr_low[HSL_P_NR_HI] = fixed_device_strap[1]; // RULE_11
         gr_low[HSL_P_NR_LO] = fixed_device_strap[0]; // RULE_11
         am_low[HSL_P_AM_MTT] = multi_translator_strap; // RULE_16
         am_low[HSL_P_AM_GANG] = gang_strap; // RULE_17
         am_dark[HSL_P_AM_INDICATOR_ENABLE_STRAP] = !indicator_enable_strap; // RULE_15
      end
   end

   // Output flops. In reset the power enables sit at the inactive level of the
   // live strap so no port is powered by accident while the core is held.
   logic [NPORT:1] next_pwr;
   logic [NPORT:1] next_gr;
   logic [NPORT:1] next_am;
   logic [NPORT:1] next_oe_n;
   logic next_pullup;
   logic [NPORT:1] pwr_on;
   logic [NPORT:1] gr_on;
   logic [NPORT:1] am_on;

   always_comb begin
      pwr_on = port_power_req & ~dis_mask; // RULE_02 RULE_07
      gr_on = green_req & ~dis_mask;
      am_on = amber_req & ~dis_mask & ~am_dark;
      if (!support) begin
         gr_on = HSL_MASK_NONE;
         am_on = HSL_MASK_NONE;
      end
      next_pwr = pol ? pwr_on : ~pwr_on; // RULE_03
      next_gr = gr_on ^ gr_low; // RULE_04 RULE_05 RULE_12
      next_am = am_on ^ am_low; // RULE_13
      next_oe_n = HSL_MASK_NONE;
      next_pullup = vbus_sync && (state == HSL_RUN); // RULE_01
      if (sys_rst) begin
         next_pwr = pol_sync ? HSL_MASK_NONE : HSL_ALL_LOW; // RULE_14
         next_oe_n = HSL_ALL_LOW;
         next_pullup = 1'h0;
      end else if (state == HSL_HOLD) begin
         next_pwr = pol_sync ? HSL_MASK_NONE : HSL_ALL_LOW; // RULE_14
         next_oe_n = HSL_ALL_LOW;
         next_pullup = 1'h0;
      end
   end

   always_ff @(posedge clk) begin
      port_power_enable_out <= next_pwr;
      first_colour_led_out <= next_gr;
      second_colour_led_out <= next_am;
      first_colour_led_oe_n <= next_oe_n;
      second_colour_led_oe_n <= next_oe_n;
      pullup_enable <= next_pullup;
   end

   assign port_disabled = dis_mask;
   assign port_fixed = fix_mask;
   assign gang_mode = gang_strap & ~ext_cfg;
   assign multi_translator_en = multi_translator_strap & ~ext_cfg;
   assign led_support = support;

endmodule : hsl_strap_led

// ### verif/hsl_board.sv
module hsl_board (
   input wire logic [7:1] strap_gr,
   input wire logic [7:1] strap_am,
   input wire logic [7:1] first_colour_led_out,
   input wire logic [7:1] first_colour_led_oe_n,
   input wire logic [7:1] second_colour_led_out,
   input wire logic [7:1] second_colour_led_oe_n,
   output logic [7:1] first_colour_led_in,
   output logic [7:1] second_colour_led_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released pin rests at its strap resistor, so the hub reads the strap there.
   assign first_colour_led_in = (first_colour_led_oe_n & strap_gr)
      | (~first_colour_led_oe_n & first_colour_led_out);
   assign second_colour_led_in = (second_colour_led_oe_n & strap_am)
      | (~second_colour_led_oe_n & second_colour_led_out);
endmodule : hsl_board

// ### verif/hsl_strap_led_asserts.sv
module hsl_strap_led_chk #(
   parameter int NPORT = 7
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic upstream_power_detect,
   input wire logic pullup_enable,
   input wire logic power_polarity_strap,
   input wire logic [NPORT:1] port_power_req,
   input wire logic [NPORT:1] port_power_enable_out,
   input wire logic [NPORT:1] green_req,
   input wire logic [NPORT:1] amber_req,
   input wire logic [NPORT:1] first_colour_led_in,
   input wire logic [NPORT:1] first_colour_led_out,
   input wire logic [NPORT:1] first_colour_led_oe_n,
   input wire logic [NPORT:1] second_colour_led_out,
   input wire logic [NPORT:1] second_colour_led_oe_n,
   input wire logic [NPORT:1] port_disabled,
   input wire logic [NPORT:1] port_fixed,
   input wire logic gang_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:1] pol_s;
   logic [4:1] led_s1, led_s2, led_q;
   logic pol_q;
   // The shadow copy assumes straps stay steady for a few cycles around release.
   always_ff @(posedge clk) begin
      pol_s <= {pol_s[1], power_polarity_strap};
      led_s1 <= first_colour_led_in[4:1];
      led_s2 <= led_s1;
      if (sys_rst) begin
         pol_q <= pol_s[2];
         led_q <= led_s2;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_rel;
      $past(sys_rst) && !sys_rst;
   endsequence
   sequence s_run;
      !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3);
   endsequence
   AST_PULLUP: assert property (pullup_enable |-> $past(upstream_power_detect, 3))
      else $error("pull-up on without upstream power");
   AST_GREEN_HI: assert property (((~first_colour_led_oe_n & ~$past(green_req)
      & ~first_colour_led_out) & 7'h70) == 7'h00) else $error("green 7:5 not active low");
   AST_AMBER_HI: assert property (((~second_colour_led_oe_n & ~$past(amber_req)
      & ~second_colour_led_out) & 7'h70) == 7'h00) else $error("amber 7:5 not active low");
   AST_PWR_RUN: assert property (s_run |-> port_power_enable_out
      == (($past(port_power_req) & ~$past(port_disabled)) ^ {NPORT{~pol_q}}))
      else $error("power enable level wrong");
   // The enables only settle once the strap synchroniser has been filled in reset.
   AST_PWR_RST: assert property (disable iff (1'b0) sys_rst && $past(sys_rst)
      && $past(sys_rst, 2) && $past(sys_rst, 3)
      |-> port_power_enable_out == {NPORT{~$past(power_polarity_strap, 3)}})
      else $error("power enable in reset wrong");
   AST_DIS: assert property (port_disabled != 7'h00 |-> port_disabled
      == {|led_q[4:3], led_q[4], &led_q[4:3], 4'h0}) else $error("disable mask wrong");
   AST_FIX: assert property (port_fixed != 7'h00 |-> port_fixed
      == {4'h0, &led_q[2:1], led_q[2], |led_q[2:1]}) else $error("fixed mask wrong");
   AST_RELEASE: assert property (s_rel |-> ##1
      (&first_colour_led_oe_n && &second_colour_led_oe_n)
      ##1 (first_colour_led_oe_n == 7'h00 && second_colour_led_oe_n == 7'h00))
      else $error("pin release order wrong");
endmodule : hsl_strap_led_chk

// ### verif/hsl_strap_led_tb.sv
module hsl_strap_led_tb import hsl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic upstream_power_detect = 1'b0;
   logic power_polarity_strap = 1'b1;
   logic [7:1] port_power_req = 7'h00;
   logic [7:1] green_req = 7'h00;
   logic [7:1] amber_req = 7'h00;
   logic [7:1] strap_gr = 7'h00;
   logic [7:1] strap_am = 7'h00;
   logic [31:0] reg_rdata, rv;
   logic pullup_enable, gang_mode, multi_translator_en, led_support;
   logic [7:1] port_power_enable_out, port_disabled, port_fixed;
   logic [7:1] first_colour_led_in, first_colour_led_out, first_colour_led_oe_n;
   logic [7:1] second_colour_led_in, second_colour_led_out, second_colour_led_oe_n;
   int fails = 0;
   int check_count = 0;
   hsl_strap_led hsl_strap_led_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .upstream_power_detect(upstream_power_detect),
      .pullup_enable(pullup_enable),
      .power_polarity_strap(power_polarity_strap),
      .port_power_req(port_power_req),
      .port_power_enable_out(port_power_enable_out),
      .green_req(green_req),
      .amber_req(amber_req),
      .first_colour_led_in(first_colour_led_in),
      .first_colour_led_out(first_colour_led_out),
      .first_colour_led_oe_n(first_colour_led_oe_n),
      .second_colour_led_in(second_colour_led_in),
      .second_colour_led_out(second_colour_led_out),
      .second_colour_led_oe_n(second_colour_led_oe_n),
      .port_disabled(port_disabled),
      .port_fixed(port_fixed),
      .gang_mode(gang_mode),
      .multi_translator_en(multi_translator_en),
      .led_support(led_support)
   );
   hsl_board hsl_board_inst (
      .strap_gr(strap_gr),
      .strap_am(strap_am),
      .first_colour_led_out(first_colour_led_out),
      .first_colour_led_oe_n(first_colour_led_oe_n),
      .second_colour_led_out(second_colour_led_out),
      .second_colour_led_oe_n(second_colour_led_oe_n),
      .first_colour_led_in(first_colour_led_in),
      .second_colour_led_in(second_colour_led_in)
   );
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic restart(input logic pol, input logic [7:1] gs, input logic [7:1] as);
      @(posedge clk);
      sys_rst <= 1'b1;
      power_polarity_strap <= pol;
      strap_gr <= gs;
      strap_am <= as;
      green_req <= 7'h00;
      amber_req <= 7'h00;
      tick(16);
      chk(32'(port_power_enable_out), 32'({7{~pol}}));
      @(posedge clk);
      sys_rst <= 1'b0;
      tick(4);
   endtask : restart
   task automatic t_straps();
      logic [1:0] c;
      logic [2:0] k;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         k = {c != 2'h0, c[1], &c} | {3{~c[0]}};
         restart(1'b1, {3'h0, c, c}, {3'h0, c[0], 1'b0, c});
         chk(32'(port_disabled), 32'({c != 2'h0, c[1], &c, 4'h0}));
         chk(32'(port_fixed), 32'({4'h0, &c, c[1], c != 2'h0}));
         chk(32'({gang_mode, multi_translator_en, led_support}), 32'({c[0], c}));
         chk(32'({first_colour_led_out[4:1], second_colour_led_out[2:1]}), 32'({c, c, c}));
         @(posedge clk);
         green_req <= 7'h7F;
         amber_req <= 7'h7F;
         tick(2);
         chk(32'({first_colour_led_out[4:1], second_colour_led_out[2:1]}),
            32'({c, c, c} ^ {6{c[0]}}));
         chk(32'(first_colour_led_out[7:5]), 32'(k));
         chk(32'(second_colour_led_out[7:3]), 32'({k, {2{~c[0]}}}));
         rd(HSL_ADDR_STATUS, rv);
         chk(32'(rv[4:1]), 32'({c, c}));
      end
      $display("t_straps done");
   endtask : t_straps
   task automatic t_power();
      for (int p = 0; p < 2; p++) begin
         restart(1'(p), 7'h08, 7'h00);
         @(posedge clk);
         port_power_req <= 7'h7F;
         tick(3);
         chk(32'(port_power_enable_out), 32'(7'h1F ^ {7{~1'(p)}}));
         @(posedge clk);
         power_polarity_strap <= ~1'(p);
         tick(5);
         chk(32'(port_power_enable_out), 32'(7'h1F ^ {7{~1'(p)}}));
      end
      $display("t_power done");
   endtask : t_power
   task automatic t_pullup();
      @(posedge clk);
      upstream_power_detect <= 1'b1;
      tick(5);
      chk(32'(pullup_enable), 32'h1);
      @(posedge clk);
      upstream_power_detect <= 1'b0;
      tick(5);
      chk(32'(pullup_enable), 32'h0);
      $display("t_pullup done");
   endtask : t_pullup
   task automatic t_regs();
      restart(1'b1, 7'h0F, 7'h00);
      wr(HSL_ADDR_CTRL, 32'h3);
      tick(2);
      chk(32'({port_disabled, first_colour_led_out}), 32'h007F);
      @(posedge clk);
      green_req <= 7'h7F;
      tick(2);
      chk(32'(first_colour_led_out), 32'h0);
      wr(HSL_ADDR_STATUS, 32'hFFFF);
      rd(4'hC, rv);
      chk(rv, 32'h0);
      rd(HSL_ADDR_CTRL, rv);
      chk(rv, 32'h3);
      rd(HSL_ADDR_STATUS, rv);
      chk(rv, 32'h21F);
      $display("t_regs done");
   endtask : t_regs
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      give_verdict();
   end
   initial begin
      t_straps();
      t_power();
      t_pullup();
      t_regs();
      give_verdict();
   end
endmodule : hsl_strap_led_tb
bind hsl_strap_led hsl_strap_led_chk #(.NPORT(NPORT)) hsl_strap_led_chk_inst (
   .clk(clk),
   .sys_rst(sys_rst),
   .upstream_power_detect(upstream_power_detect),
   .pullup_enable(pullup_enable),
   .power_polarity_strap(power_polarity_strap),
   .port_power_req(port_power_req),
   .port_power_enable_out(port_power_enable_out),
   .green_req(green_req),
   .amber_req(amber_req),
   .first_colour_led_in(first_colour_led_in),
   .first_colour_led_out(first_colour_led_out),
   .first_colour_led_oe_n(first_colour_led_oe_n),
   .second_colour_led_out(second_colour_led_out),
   .second_colour_led_oe_n(second_colour_led_oe_n),
   .port_disabled(port_disabled),
   .port_fixed(port_fixed),
   .gang_mode(gang_mode)
);
